// ---- common/dsm_pkg.sv ----
// Purpose: Shared constants and types of the data space map decoder
// Assumes: 8-bit data space, 12-bit program space
// Notes:   Offsets are data space byte addresses

package dsm_pkg;

    // Data space offsets
    localparam logic [7:0] IDX_BASE       = 8'h80;
    localparam logic [7:0] IDX_LAST       = 8'h83;
    localparam logic [7:0] PORT_A_DATA    = 8'hC0;
    localparam logic [7:0] PORT_B_DATA    = 8'hC1;
    localparam logic [7:0] PORT_A_DIR     = 8'hC4;
    localparam logic [7:0] PORT_B_DIR     = 8'hC5;
    localparam logic [7:0] INT_OPTION     = 8'hC8;
    localparam logic [7:0] ROM_WIN_SEL    = 8'hC9;
    localparam logic [7:0] PORT_A_OPT     = 8'hCC;
    localparam logic [7:0] PORT_B_OPT     = 8'hCD;
    localparam logic [7:0] CONV_RESULT    = 8'hD0;
    localparam logic [7:0] CONV_CONTROL   = 8'hD1;
    localparam logic [7:0] TIMER_PRESCALE = 8'hD2;
    localparam logic [7:0] TIMER_COUNT    = 8'hD3;
    localparam logic [7:0] TIMER_STATUS   = 8'hD4;
    localparam logic [7:0] WATCHDOG       = 8'hD8;
    localparam logic [7:0] ACCUMULATOR    = 8'hFF;
    localparam logic [7:0] ROM_WIN_FIRST  = 8'h40;
    localparam logic [7:0] ROM_WIN_LAST   = 8'h7F;

    // Field layouts
    localparam int WIN_SEL_BITS  = 6;
    localparam int WIN_OFS_BITS  = 6;
    localparam int PC_BITS       = 12;
    localparam int STACK_LEVELS  = 6;
    localparam logic [7:0] CONV_RO_MASK = 8'h80;

    // Values after reset, and the value unmapped places read
    localparam logic [7:0] PORT_RST       = 8'h00;
    localparam logic [7:0] CONV_CTRL_RST  = 8'h40;
    localparam logic [7:0] PRESCALE_RST   = 8'h7F;
    localparam logic [7:0] COUNT_RST      = 8'hFF;
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // Cycles spent in the reset phase before the mode pin is caught
    localparam logic [1:0] RESET_PHASE_CYCLES = 2'h3;

    // Answer engine states
    typedef enum logic [2:0] {
        DSM_ST_IDLE     = 3'b001,
        DSM_ST_ROM_WAIT = 3'b010,
        DSM_ST_EXT_WAIT = 3'b100
    } dsm_bus_state_t;

    // Core data space request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsm_bus_req_t;

    // Core program counter control
    typedef struct packed {
        logic                load;
        logic                push;
        logic                pop;
        logic                inc;
        logic [PC_BITS-1:0]  target;
    } dsm_pc_ctl_t;

endpackage

// ---- design/dsm_decoder.sv ----
// Purpose: Data space decoder, register map, program counter and stack
// Assumes: One clock; program memory answers in the cycle it is addressed
// Notes:   Peripheral internals live elsewhere; only their registers here
// Notes on behaviour
// - Interrupt request only on falling interrupt pin
// - Reset overrides everything, the interrupt included
// - Port lines reset as inputs with pull-up
// - Mode pin high during reset selects programming
// - Twelve-bit program counter addresses 4K bytes
// - Six-entry twelve-bit return stack
// - Window reads return program memory bytes
// - Protection refuses external program memory reads
// - Protection stays until full erase clears it; reset also clears it
// - Index and short direct registers at 80h-83h
// - Accumulator at FFh, read/write
// - Port data registers at C0h, C1h, cleared
// - Port direction registers at C4h, C5h, cleared
// - Port option registers at CCh, CDh, cleared
// - Interrupt option and window select write-only
// - Converter result read-only, control resets 40h
// - Timer registers reset 7Fh, FFh, 00h
// - Watchdog register at D8h, read/write
// - Window spans 40h-7Fh, block from select
// - Port read: latch if output, pin if input

`timescale 1ns/1ns
`default_nettype none

module dsm_decoder #(
    parameter int PORT_WIDTH = 8
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire dsm_pkg::dsm_bus_req_t         bus_req,
    output logic                               bus_busy,
    output logic                               rd_valid,
    output logic [7:0]                         rd_data,
    input  wire dsm_pkg::dsm_pc_ctl_t          pc_ctl,
    output logic [dsm_pkg::PC_BITS-1:0]        pc,
    output logic [2:0]                         stack_depth,
    output logic [dsm_pkg::PC_BITS-1:0]        prog_addr,
    input  wire logic [7:0]                    prog_data,
    input  wire logic                          nmi_pin,
    input  wire logic                          nmi_ack,
    output logic                               nmi_request,
    input  wire logic                          vpp_high,
    output logic                               program_mode,
    input  wire logic                          protect_option,
    input  wire logic                          full_erase,
    output logic                               readout_protected,
    input  wire logic                          ext_rd_req,
    input  wire logic [dsm_pkg::PC_BITS-1:0]   ext_rd_addr,
    output logic                               ext_rd_valid,
    output logic [7:0]                         ext_rd_data,
    input  wire logic [7:0]                    conv_result_in,
    input  wire logic                          conv_done_in,
    input  wire logic [PORT_WIDTH-1:0]         port_a_pin_in,
    input  wire logic [PORT_WIDTH-1:0]         port_b_pin_in,
    output logic [PORT_WIDTH-1:0]              port_a_pin_out,
    output logic [PORT_WIDTH-1:0]              port_b_pin_out,
    output logic [PORT_WIDTH-1:0]              port_a_pin_oe_n,
    output logic [PORT_WIDTH-1:0]              port_b_pin_oe_n,
    output logic [PORT_WIDTH-1:0]              port_a_pullup,
    output logic [PORT_WIDTH-1:0]              port_b_pullup
);

    localparam int PCW = dsm_pkg::PC_BITS;
    localparam int SL  = dsm_pkg::STACK_LEVELS;
    localparam int WSB = dsm_pkg::WIN_SEL_BITS;
    localparam int WOB = dsm_pkg::WIN_OFS_BITS;
    localparam logic [2:0] FULL_DEPTH = 3'h6;

    // Whole module state, registered as one word
    typedef struct packed {
        dsm_pkg::dsm_bus_state_t    state;
        logic                       busy;
        logic                       rd_valid;
        logic [7:0]                 rd_data;
        logic                       ext_valid;
        logic [7:0]                 ext_data;
        logic [PCW-1:0]             pc;
        logic [SL-1:0][PCW-1:0]     stack;
        logic [2:0]                 depth;
        logic [PCW-1:0]             prog_addr;
        logic                       nmi_s1;
        logic                       nmi_s2;
        logic                       nmi_prev;
        logic                       nmi_req;
        logic                       vpp_s1;
        logic                       vpp_s2;
        logic [1:0]                 phase_cnt;
        logic                       phase_done;
        logic                       prog_mode;
        logic                       protect;
        logic [3:0][7:0]            idx;
        logic [7:0]                 acc;
        logic [PORT_WIDTH-1:0]      a_data;
        logic [PORT_WIDTH-1:0]      b_data;
        logic [PORT_WIDTH-1:0]      a_dir;
        logic [PORT_WIDTH-1:0]      b_dir;
        logic [PORT_WIDTH-1:0]      a_opt;
        logic [PORT_WIDTH-1:0]      b_opt;
        logic [PORT_WIDTH-1:0]      a_pin_s1;
        logic [PORT_WIDTH-1:0]      a_pin_s2;
        logic [PORT_WIDTH-1:0]      b_pin_s1;
        logic [PORT_WIDTH-1:0]      b_pin_s2;
        logic [7:0]                 int_opt;
        logic [WSB-1:0]             win_sel;
        logic [7:0]                 conv_ctrl;
        logic [7:0]                 prescale;
        logic [7:0]                 count;
        logic [7:0]                 tstatus;
        logic [7:0]                 wdog;
        logic [PORT_WIDTH-1:0]      a_out;
        logic [PORT_WIDTH-1:0]      b_out;
        logic [PORT_WIDTH-1:0]      a_oe_n;
        logic [PORT_WIDTH-1:0]      b_oe_n;
        logic [PORT_WIDTH-1:0]      a_pu;
        logic [PORT_WIDTH-1:0]      b_pu;
    } dsm_state_t;

    dsm_state_t s;
    dsm_state_t next_s;

    // Address falls inside the program memory window
    function automatic logic in_window(input logic [7:0] addr);
        in_window = (addr >= dsm_pkg::ROM_WIN_FIRST) &&
                    (addr <= dsm_pkg::ROM_WIN_LAST);
    endfunction

    // Address falls on the index and short direct group
    function automatic logic in_index(input logic [7:0] addr);
        in_index = (addr >= dsm_pkg::IDX_BASE) &&
                   (addr <= dsm_pkg::IDX_LAST);
    endfunction

    // Port read: latch on output lines, live pin on input lines
    function automatic logic [7:0] port_view(
        input logic [PORT_WIDTH-1:0] dir,
        input logic [PORT_WIDTH-1:0] latch,
        input logic [PORT_WIDTH-1:0] pin
    );
        port_view = 8'((dir & latch) | (~dir & pin));
    endfunction

    // Register read mux; write-only and reserved places read a constant
    function automatic logic [7:0] read_mux(
        input dsm_state_t    st,
        input logic [7:0]    addr,
        input logic [7:0]    conv_res,
        input logic          conv_done
    );
        read_mux = dsm_pkg::UNMAPPED_READ;
        if (in_index(addr))
            read_mux = st.idx[addr[1:0]];
        else
        begin
            case (addr)
                dsm_pkg::ACCUMULATOR:
                    read_mux = st.acc;
                dsm_pkg::PORT_A_DATA:
                    read_mux = port_view(st.a_dir, st.a_data,
                                         st.a_pin_s2);
                dsm_pkg::PORT_B_DATA:
                    read_mux = port_view(st.b_dir, st.b_data,
                                         st.b_pin_s2);
                dsm_pkg::PORT_A_DIR:   read_mux = 8'(st.a_dir);
                dsm_pkg::PORT_B_DIR:   read_mux = 8'(st.b_dir);
                dsm_pkg::PORT_A_OPT:   read_mux = 8'(st.a_opt);
                dsm_pkg::PORT_B_OPT:   read_mux = 8'(st.b_opt);
                dsm_pkg::CONV_RESULT:  read_mux = conv_res;
                dsm_pkg::CONV_CONTROL:
                    read_mux = (st.conv_ctrl & ~dsm_pkg::CONV_RO_MASK) |
                               (conv_done ? dsm_pkg::CONV_RO_MASK
                                          : 8'h00);
                dsm_pkg::TIMER_PRESCALE: read_mux = st.prescale;
                dsm_pkg::TIMER_COUNT:    read_mux = st.count;
                dsm_pkg::TIMER_STATUS:   read_mux = st.tstatus;
                dsm_pkg::WATCHDOG:       read_mux = st.wdog;
                // Write-only places give no readback
                default: read_mux = dsm_pkg::UNMAPPED_READ;
            endcase
        end
    endfunction

    // Next state of the whole block
    always_comb
    begin
        next_s = s;
        next_s.rd_valid  = 1'b0;
        next_s.ext_valid = 1'b0;

        // Two-flop synchronisers for every pin
        next_s.nmi_s1   = nmi_pin;
        next_s.nmi_s2   = s.nmi_s1;
        next_s.nmi_prev = s.nmi_s2;
        next_s.vpp_s1   = vpp_high;
        next_s.vpp_s2   = s.vpp_s1;
        next_s.a_pin_s1 = port_a_pin_in;
        next_s.a_pin_s2 = s.a_pin_s1;
        next_s.b_pin_s1 = port_b_pin_in;
        next_s.b_pin_s2 = s.b_pin_s1;

        // Falling edge sets the request; a new edge beats the ack
        if (nmi_ack)
            next_s.nmi_req = 1'b0;
        if (s.nmi_prev && !s.nmi_s2)
            next_s.nmi_req = 1'b1;

        // Mode pin caught once, after the synchronisers have filled
        if (!s.phase_done)
        begin
            if (s.phase_cnt == dsm_pkg::RESET_PHASE_CYCLES)
            begin
                next_s.prog_mode  = s.vpp_s2;
                next_s.phase_done = 1'b1;
            end
            else
                next_s.phase_cnt = s.phase_cnt + 2'h1;
        end

        // Protection is sticky; erase clears it, the option bit wins
        if (full_erase)
            next_s.protect = 1'b0;
        if (protect_option)
            next_s.protect = 1'b1;

        // Program counter and return stack
        if (pc_ctl.push)
        begin
            for (int i = SL - 1; i > 0; i--)
                next_s.stack[i] = s.stack[i-1];
            next_s.stack[0] = s.pc;
            if (s.depth != FULL_DEPTH)
                next_s.depth = s.depth + 3'h1;
            next_s.pc = pc_ctl.target;
        end
        else if (pc_ctl.pop)
        begin
            for (int i = 0; i < SL - 1; i++)
                next_s.stack[i] = s.stack[i+1];
            next_s.pc = s.stack[0];
            if (s.depth != 3'h0)
                next_s.depth = s.depth - 3'h1;
        end
        else if (pc_ctl.load)
            next_s.pc = pc_ctl.target;
        else if (pc_ctl.inc)
            next_s.pc = s.pc + 12'h001;

        // Request engine; busy cycles ignore new requests
        case (s.state)
            dsm_pkg::DSM_ST_IDLE:
            begin
                next_s.prog_addr = next_s.pc;
                if (bus_req.rd && in_window(bus_req.addr))
                begin
                    next_s.prog_addr = {s.win_sel,
                                        bus_req.addr[WOB-1:0]};
                    next_s.state = dsm_pkg::DSM_ST_ROM_WAIT;
                    next_s.busy  = 1'b1;
                end
                else if (bus_req.rd)
                begin
                    next_s.rd_data  = read_mux(s, bus_req.addr,
                                               conv_result_in,
                                               conv_done_in);
                    next_s.rd_valid = 1'b1;
                end
                else if (bus_req.wr)
                begin
                    if (in_index(bus_req.addr))
                        next_s.idx[bus_req.addr[1:0]] =
                            bus_req.wdata;
                    else
                    begin
                        case (bus_req.addr)
                            dsm_pkg::ACCUMULATOR:
                                next_s.acc = bus_req.wdata;
                            dsm_pkg::PORT_A_DATA:
                                next_s.a_data =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::PORT_B_DATA:
                                next_s.b_data =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::PORT_A_DIR:
                                next_s.a_dir =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::PORT_B_DIR:
                                next_s.b_dir =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::PORT_A_OPT:
                                next_s.a_opt =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::PORT_B_OPT:
                                next_s.b_opt =
                                    bus_req.wdata[PORT_WIDTH-1:0];
                            dsm_pkg::INT_OPTION:
                                next_s.int_opt = bus_req.wdata;
                            dsm_pkg::ROM_WIN_SEL:
                                next_s.win_sel =
                                    bus_req.wdata[WSB-1:0];
                            dsm_pkg::CONV_CONTROL:
                                next_s.conv_ctrl =
                                    bus_req.wdata &
                                    ~dsm_pkg::CONV_RO_MASK;
                            dsm_pkg::TIMER_PRESCALE:
                                next_s.prescale = bus_req.wdata;
                            dsm_pkg::TIMER_COUNT:
                                next_s.count = bus_req.wdata;
                            dsm_pkg::TIMER_STATUS:
                                next_s.tstatus = bus_req.wdata;
                            dsm_pkg::WATCHDOG:
                                next_s.wdog = bus_req.wdata;
                            // Reserved and read-only places keep state
                            default: next_s.wdog = s.wdog;
                        endcase
                    end
                end
                else if (ext_rd_req && s.prog_mode)
                begin
                    next_s.prog_addr = ext_rd_addr;
                    next_s.state = dsm_pkg::DSM_ST_EXT_WAIT;
                    next_s.busy  = 1'b1;
                end
            end
            dsm_pkg::DSM_ST_ROM_WAIT:
            begin
                next_s.rd_data   = prog_data;
                next_s.rd_valid  = 1'b1;
                next_s.prog_addr = next_s.pc;
                next_s.state     = dsm_pkg::DSM_ST_IDLE;
                next_s.busy      = 1'b0;
            end
            dsm_pkg::DSM_ST_EXT_WAIT:
            begin
                // Protected parts answer with zero, never the contents
                next_s.ext_data  = s.protect ? 8'h00 : prog_data;
                next_s.ext_valid = 1'b1;
                next_s.prog_addr = next_s.pc;
                next_s.state     = dsm_pkg::DSM_ST_IDLE;
                next_s.busy      = 1'b0;
            end
            default:
            begin
                next_s.state = dsm_pkg::DSM_ST_IDLE;
                next_s.busy  = 1'b0;
            end
        endcase

        // Pin drivers follow the new register values
        next_s.a_out  = next_s.a_data;
        next_s.b_out  = next_s.b_data;
        next_s.a_oe_n = ~next_s.a_dir;
        next_s.b_oe_n = ~next_s.b_dir;
        next_s.a_pu   = ~next_s.a_dir & ~next_s.a_opt;
        next_s.b_pu   = ~next_s.b_dir & ~next_s.b_opt;
    end

    // State register; reset outranks every other source
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s           <= '0;
            s.state     <= dsm_pkg::DSM_ST_IDLE;
            s.a_data    <= dsm_pkg::PORT_RST;
            s.b_data    <= dsm_pkg::PORT_RST;
            s.a_oe_n    <= '1;
            s.b_oe_n    <= '1;
            s.a_pu      <= '1;
            s.b_pu      <= '1;
            s.conv_ctrl <= dsm_pkg::CONV_CTRL_RST;
            s.prescale  <= dsm_pkg::PRESCALE_RST;
            s.count     <= dsm_pkg::COUNT_RST;
            s.tstatus   <= dsm_pkg::STATUS_RST;
            s.nmi_s1    <= 1'b1;   // Idle-high pin, no false edge
            s.nmi_s2    <= 1'b1;
            s.nmi_prev  <= 1'b1;
        end
        else
            s <= next_s;
    end

    // Outputs straight from the state word
    assign bus_busy          = s.busy;
    assign rd_valid          = s.rd_valid;
    assign rd_data           = s.rd_data;
    assign pc                = s.pc;
    assign stack_depth       = s.depth;
    assign prog_addr         = s.prog_addr;
    assign nmi_request       = s.nmi_req;
    assign program_mode      = s.prog_mode;
    assign readout_protected = s.protect;
    assign ext_rd_valid      = s.ext_valid;
    assign ext_rd_data       = s.ext_data;
    assign port_a_pin_out    = s.a_out;
    assign port_b_pin_out    = s.b_out;
    assign port_a_pin_oe_n   = s.a_oe_n;
    assign port_b_pin_oe_n   = s.b_oe_n;
    assign port_a_pullup     = s.a_pu;
    assign port_b_pullup     = s.b_pu;

endmodule

`default_nettype wire

// ---- test/dsm_checker.sv ----
// Purpose: Port-level assertions for the data space decoder
// Assumes: One clock domain, reset_n active low
// Notes:   Watches a subset of the decoder ports
`timescale 1ns/1ns
`default_nettype none
module dsm_checker (
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire dsm_pkg::dsm_bus_req_t bus_req,
    input wire logic                  bus_busy,
    input wire logic                  rd_valid,
    input wire logic [7:0]            rd_data,
    input wire dsm_pkg::dsm_pc_ctl_t  pc_ctl,
    input wire logic [11:0]           pc,
    input wire logic [2:0]            stack_depth,
    input wire logic [11:0]           prog_addr,
    input wire logic [7:0]            prog_data,
    input wire logic                  nmi_pin,
    input wire logic                  nmi_request,
    input wire logic                  readout_protected,
    input wire logic                  ext_rd_valid,
    input wire logic [7:0]            ext_rd_data,
    input wire logic [7:0]            port_a_pullup
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Accepted reads, split by window hit; busy requests are dropped
    wire win = bus_req.rd && !bus_busy && bus_req.addr[7:6] == 2'b01;
    wire rrd = bus_req.rd && !bus_busy && bus_req.addr[7:6] != 2'b01;
    AST_REG_RD: assert property (rrd |=> rd_valid)
        else $error("register read not answered");
    AST_WIN: assert property (win |=> bus_busy ##1
        (rd_valid && rd_data == $past(prog_data))) else $error("window data");
    AST_WIN_ADR: assert property
        (win |=> prog_addr[5:0] == $past(bus_req.addr[5:0]))
        else $error("window offset");
    AST_PUSH: assert property
        (pc_ctl.push |=> pc == $past(pc_ctl.target))
        else $error("push target");
    AST_DEPTH: assert property (stack_depth <= 3'h6)
        else $error("stack too deep");
    AST_NMI: assert property
        ($fell(nmi_pin) |-> ##[1:5] nmi_request)
        else $error("falling edge lost");
    // The answer uses the protection state of the cycle before it shows
    AST_EXT: assert property
        (ext_rd_valid && $past(readout_protected) |-> ext_rd_data == 8'h00)
        else $error("protected data leaked");
    AST_PULL: assert property ($rose(reset_n) |-> &port_a_pullup)
        else $error("pull-up off after reset");
    cover property (win);
    cover property (ext_rd_valid && readout_protected);
    cover property (pc_ctl.push && stack_depth == 3'h6);
    cover property ($rose(nmi_request));
endmodule
bind dsm_decoder dsm_checker dsm_checker_i (.*);
`default_nettype wire

// ---- test/dsm_decoder_tb_top.sv ----
// Purpose: Self-checking bench for the data space decoder
// Assumes: Program memory model answers in the same cycle
// Notes:   Port B pins held constant; converter done raised once
`timescale 1ns/1ns
`default_nettype none
module dsm_decoder_tb_top;
    dsm_pkg::dsm_bus_req_t bus_req;
    dsm_pkg::dsm_pc_ctl_t  pc_ctl;
    logic clk, reset_n, bus_busy, rd_valid, nmi_pin, nmi_ack, nmi_request;
    logic vpp_high, program_mode, protect_option, full_erase, ext_rd_req;
    logic readout_protected, ext_rd_valid, conv_done_in;
    logic [2:0] stack_depth;
    logic [7:0] rd_data, prog_data, ext_rd_data, conv_result_in;
    logic [11:0] pc, prog_addr, ext_rd_addr;
    logic [7:0] port_a_pin_in, port_b_pin_in, port_a_pin_out, port_b_pin_out;
    logic [7:0] port_a_pin_oe_n, port_b_pin_oe_n, port_a_pullup, port_b_pullup;
    int num_errors, samples_checked, cyc;
    dsm_decoder dsm_decoder_i (.*);
    dsm_prog_mem dsm_prog_mem_i (.*);
    initial begin clk = 0; forever #2 clk = ~clk; end
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cut a hang short well after the expected run length
    always @(posedge clk)
        if (++cyc > 5000) begin num_errors++; give_verdict; end
    task automatic chk(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end
    endtask
    // Bus cycles: request raised after one edge, dropped after the next
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) bus_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk) bus_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk) bus_req <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk) bus_req <= '0;
        #1 for (int n = 0; n < 3 && rd_valid !== 1'b1; n++) @(posedge clk) #1;
        chk({rd_valid, rd_data}, {1'b1, e});
    endtask
    task automatic xr(input logic [7:0] e);
        @(posedge clk) ext_rd_req <= 1'b1;
        @(posedge clk) ext_rd_req <= 1'b0;
        @(posedge clk) #1 chk({ext_rd_valid, ext_rd_data}, {1'b1, e});
    endtask
    task automatic t_reset;
        logic [15:0] tbl [8] = '{16'hD140, 16'hD27F, 16'hD3FF, 16'hD400,
                                 16'hC400, 16'hC500, 16'hCC00, 16'hC000};
        chk({port_a_pullup, port_b_pullup}, 16'hFFFF);
        chk({port_a_pin_oe_n, port_b_pin_oe_n}, 16'hFFFF);
        chk({port_a_pin_out, port_b_pin_out}, 16'h0000);
        foreach (tbl[i])
            rd(tbl[i][15:8], tbl[i][7:0]);
        $display("t_reset done");
    endtask
    task automatic t_rw;
        logic [7:0] ad [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'hD8,
                               8'hD2, 8'hCD};
        foreach (ad[i]) wr(ad[i], 8'(8'hA0 + i));
        foreach (ad[i]) rd(ad[i], 8'(8'hA0 + i));
        wr(8'hD0, 8'h11); rd(8'hD0, conv_result_in);
        // Bit 7 of the control word is status: writes drop it
        wr(8'hD1, 8'hBF); rd(8'hD1, 8'h3F);
        @(posedge clk) conv_done_in <= 1'b1;
        rd(8'hD1, 8'hBF);
        wr(8'hC2, 8'h33); rd(8'hC2, 8'h00);
        wr(8'hC8, 8'h44); rd(8'hC8, 8'h00);
        $display("t_rw done");
    endtask
    task automatic t_port;
        wr(8'hC4, 8'hF0); wr(8'hC0, 8'h5A); wr(8'hCC, 8'h03);
        port_a_pin_in <= 8'h3C;
        repeat (3) @(posedge clk);
        rd(8'hC0, 8'h5C);
        chk({port_a_pin_oe_n, port_a_pullup}, 16'h0F0C);
        chk(port_a_pin_out, 8'h5A);
        $display("t_port done");
    endtask
    task automatic t_win;
        wr(8'hC9, 8'h05); rd(8'h45, 8'h44);
        wr(8'hC9, 8'h3F); rd(8'h7F, 8'hF0);
        $display("t_win done");
    endtask
    task automatic t_stack;
        for (int i = 1; i < 8; i++)
            @(posedge clk) pc_ctl <= {4'b0100, 12'(12'hFF0 + i)};
        @(posedge clk) pc_ctl <= {4'b0010, 12'h000};
        #1 chk({stack_depth, pc}, {3'h6, 12'hFF7});
        repeat (5) @(posedge clk);
        @(posedge clk) pc_ctl <= {4'b1000, 12'h7FF};
        #1 chk({stack_depth, pc}, {3'h0, 12'hFF1});
        // Load then step across the top bit; pc stays non-zero afterwards
        @(posedge clk) pc_ctl <= {4'b0001, 12'h000};
        #1 chk(pc, 12'h7FF);
        @(posedge clk) pc_ctl <= '0;
        #1 chk(pc, 12'h800);
        $display("t_stack done");
    endtask
    task automatic t_nmi;
        @(posedge clk) nmi_pin <= 1'b0;
        repeat (6) @(posedge clk); #1 chk(nmi_request, 1'b1);
        @(posedge clk) nmi_ack <= 1'b1;
        @(posedge clk) begin nmi_ack <= 1'b0; nmi_pin <= 1'b1; end
        repeat (6) @(posedge clk); #1 chk(nmi_request, 1'b0);
        $display("t_nmi done");
    endtask
    task automatic t_prot;
        chk(program_mode, 1'b1); xr(8'h44);
        @(posedge clk) protect_option <= 1'b1;
        @(posedge clk) protect_option <= 1'b0;
        xr(8'h00); chk(readout_protected, 1'b1);
        @(posedge clk) full_erase <= 1'b1;
        @(posedge clk) full_erase <= 1'b0;
        @(posedge clk) #1 chk(readout_protected, 1'b0);
        @(posedge clk) begin vpp_high <= 1'b0; reset_n <= 1'b0; end
        @(posedge clk) #1 chk(pc, 12'h000);
        @(posedge clk) reset_n <= 1'b1;
        repeat (6) @(posedge clk); #1 chk(program_mode, 1'b0);
        // Outside programming mode an external read gets no answer
        @(posedge clk) ext_rd_req <= 1'b1;
        repeat (2) @(posedge clk); #1 chk(ext_rd_valid, 1'b0);
        @(posedge clk) ext_rd_req <= 1'b0;
        $display("t_prot done");
    endtask
    // Main sequence; the mode pin is high through the first reset
    initial begin
        reset_n = 0; bus_req = '0; pc_ctl = '0; nmi_pin = 1; nmi_ack = 0;
        vpp_high = 1; protect_option = 0; full_erase = 0; ext_rd_req = 0;
        ext_rd_addr = 12'h145; conv_done_in = 0; conv_result_in = 8'h9C;
        port_a_pin_in = 0; port_b_pin_in = 0; num_errors = 0;
        samples_checked = 0; cyc = 0;
        repeat (2) @(posedge clk); reset_n <= 1'b1;
        t_reset; t_rw; t_port; t_win; t_stack; t_nmi; t_prot;
        give_verdict;
    end
endmodule
`default_nettype wire

// ---- test/dsm_prog_mem.sv ----
// Purpose: Program memory model that answers the decoder
// Assumes: Data follows the address within the same cycle
// Notes:   Byte pattern mixes both address halves so block errors show
`timescale 1ns/1ns
`default_nettype none
module dsm_prog_mem (
    input  wire logic [11:0] prog_addr,
    output logic      [7:0]  prog_data
);
    // No wait state, since the decoder samples one cycle after addressing
    assign prog_data = prog_addr[7:0] ^ {4'h0, prog_addr[11:8]};
endmodule
`default_nettype wire
